// ### include/counter_defs.vh
// constants shared by the decade counter and its register slave
`ifndef COUNTER_DEFS_VH
`define COUNTER_DEFS_VH

// ============================================================
// register byte offsets
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_PRESET 8'h04
`define REG_COMMAND 8'h08
`define REG_STATUS 8'h0c
`define REG_WRAPS 8'h10
`define REG_FLAGS 8'h14

// ============================================================
// field positions
`define CTRL_ENABLE_SRC 0
`define CTRL_PAR_EN 1
`define CTRL_TRK_EN 2
`define CMD_CLEAR 0
`define CMD_LOAD 1
`define FLAG_INVALID 0
`define FLAG_WRAP 1
`define ST_CARRY 4
`define ST_INVALID 5
`define ST_PAR_EN 6
`define ST_TRK_EN 7
`define ST_LOAD_PIN 8
`define ST_CLEAR_PIN 9

// ============================================================
// reset values, counter constants and bus response codes
`define CTRL_RESET 3'h0
`define PRESET_RESET 4'h0
`define COUNT_RESET 4'h0
`define COUNT_LAST 4'h9
`define COUNT_ONE 4'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hdl/decade_stage.v
// one synchronous presettable decade counting stage
`timescale 1ns/100ps
`include "counter_defs.vh"

module decade_stage
(
  input wire clock_i,
  input wire reset_i,
  input wire sync_clear_n_i,
  input wire load_n_i,
  input wire parallel_count_enable_i,
  input wire trickle_count_enable_i,
  input wire [3:0] preset_i,
  output reg [3:0] count_o,
  output wire ripple_carry_out_o,
  output wire wrap_o
);

  reg [3:0] count_nxt;
  reg [3:0] advance;
  wire count_en;

  // ============================================================
  // next count
  assign count_en = parallel_count_enable_i & trickle_count_enable_i;

  always @*
  begin
    // invalid codes fold back within two steps
    case (count_o)
      4'h9: advance = 4'h0;
      4'ha: advance = 4'hb;
      4'hb: advance = 4'h6;
      4'hc: advance = 4'hd;
      4'hd: advance = 4'h4;
      4'he: advance = 4'hf;
      4'hf: advance = 4'h2;
      default: advance = count_o + `COUNT_ONE;
    endcase
  end

  always @*
  begin
    // clear, then load, then count, else hold
    if (!sync_clear_n_i)
      count_nxt = `COUNT_RESET;
    else if (!load_n_i)
      count_nxt = preset_i;
    else if (count_en)
      count_nxt = advance;
    else
      count_nxt = count_o;
  end

  // ============================================================
  // state register: all four bits move on the same edge
  always @(posedge clock_i)
  begin
    if (reset_i)
      count_o <= `COUNT_RESET;
    else
      count_o <= count_nxt;
  end

  // carry ignores the parallel enable so stages cascade without gating
  assign ripple_carry_out_o = trickle_count_enable_i & (count_o == `COUNT_LAST);
  assign wrap_o = count_en & sync_clear_n_i & load_n_i & (count_o == `COUNT_LAST);

endmodule // decade_stage

// ### hdl/presettable_decade_counter.v
// decade counter with pin controls and an axi4-lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "counter_defs.vh"

module presettable_decade_counter
(
  input wire clock_i,
  input wire reset_i,
  input wire sync_clear_n_i,
  input wire load_n_i,
  input wire parallel_count_enable_i,
  input wire trickle_count_enable_i,
  input wire [3:0] preset_i,
  output wire [3:0] count_o,
  output wire ripple_carry_out_o,
  input wire [7:0] s_axi_awaddr_i,
  input wire [2:0] s_axi_awprot_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire [2:0] s_axi_arprot_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i
);

  // ============================================================
  // declarations
  reg awready_r;
  reg wready_r;
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  reg [2:0] ctrl_r;
  reg [3:0] preset_r;
  reg cmd_clear_r;
  reg cmd_load_r;
  reg [31:0] wraps_r;
  reg [1:0] flags_r;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [31:0] wraps_nxt;
  reg [1:0] flags_nxt;
  wire do_write;
  wire wr_ctrl;
  wire wr_preset;
  wire wr_command;
  wire wr_wraps;
  wire wr_flags;
  wire wr_hit;
  wire par_en;
  wire trk_en;
  wire clear_n;
  wire load_n;
  wire [3:0] load_data;
  wire [3:0] count_w;
  wire carry_w;
  wire wrap_w;
  wire invalid_w;
  wire [1:0] flag_set;
  wire [1:0] flag_clr;
  wire [31:0] status_w;

  // ============================================================
  // counting stage control
  // register mode lets software drive the enables when the pins are unused
  assign par_en = ctrl_r[`CTRL_ENABLE_SRC] ? ctrl_r[`CTRL_PAR_EN] : parallel_count_enable_i;
  assign trk_en = ctrl_r[`CTRL_ENABLE_SRC] ? ctrl_r[`CTRL_TRK_EN] : trickle_count_enable_i;
  // clear and load pins stay live in both modes
  assign clear_n = sync_clear_n_i & ~cmd_clear_r;
  assign load_n = load_n_i & ~cmd_load_r;
  // pin load wins the data path; the far side holds preset_i steady
  assign load_data = load_n_i ? preset_r : preset_i;

  decade_stage u_stage
  (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .sync_clear_n_i(clear_n),
    .load_n_i(load_n),
    .parallel_count_enable_i(par_en),
    .trickle_count_enable_i(trk_en),
    .preset_i(load_data),
    .count_o(count_w),
    .ripple_carry_out_o(carry_w),
    .wrap_o(wrap_w)
  );

  assign count_o = count_w;
  // combinational so that a cascaded stage sees it in the same cycle
  assign ripple_carry_out_o = carry_w;
  assign invalid_w = (count_w > `COUNT_LAST);

  // ============================================================
  // write decode
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_ctrl = do_write & (aw_addr_r == `REG_CTRL);
  assign wr_preset = do_write & (aw_addr_r == `REG_PRESET);
  assign wr_command = do_write & (aw_addr_r == `REG_COMMAND);
  assign wr_wraps = do_write & (aw_addr_r == `REG_WRAPS);
  assign wr_flags = do_write & (aw_addr_r == `REG_FLAGS);
  assign wr_hit = wr_ctrl | wr_preset | wr_command | wr_wraps | wr_flags;

  // ============================================================
  // sticky flags: hardware set wins over a write-one clear
  assign flag_set = {wrap_w, invalid_w};
  assign flag_clr = (wr_flags & w_strb_r[0]) ? w_data_r[1:0] : 2'h0;

  always @*
  begin
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    wraps_nxt = wraps_r;
    if (wr_wraps)
      wraps_nxt = 32'h0;
    // an increment in the clearing cycle still counts
    if (wrap_w)
      wraps_nxt = wraps_nxt + 32'h1;
  end

  // ============================================================
  // read mux
  assign status_w = {22'h0, ~sync_clear_n_i, ~load_n_i, trk_en, par_en,
                     invalid_w, carry_w, count_w};

  always @*
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      `REG_CTRL: rd_mux = {29'h0, ctrl_r};
      `REG_PRESET: rd_mux = {28'h0, preset_r};
      `REG_COMMAND: rd_mux = 32'h0;
      `REG_STATUS: rd_mux = status_w;
      `REG_WRAPS: rd_mux = wraps_r;
      `REG_FLAGS: rd_mux = {30'h0, flags_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // ============================================================
  // write channels: address and data taken in either order
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i & awready_r)
      begin
        aw_addr_r <= s_axi_awaddr_i;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid_i & wready_r)
      begin
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      // one write at a time: ready returns only after the response
      if (bvalid_r & s_axi_bready_i)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // read channel
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0;
    end
    else
    begin
      if (s_axi_arvalid_i & arready_r)
      begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        rvalid_r <= 1'b1;
        arready_r <= 1'b0;
      end
      if (rvalid_r & s_axi_rready_i)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // software registers
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ctrl_r <= `CTRL_RESET;
      preset_r <= `PRESET_RESET;
      cmd_clear_r <= 1'b0;
      cmd_load_r <= 1'b0;
      wraps_r <= 32'h0;
      flags_r <= 2'h0;
    end
    else
    begin
      if (wr_ctrl & w_strb_r[0])
        ctrl_r <= w_data_r[2:0];
      if (wr_preset & w_strb_r[0])
        preset_r <= w_data_r[3:0];
      // command bits live one cycle and act at the following edge
      cmd_clear_r <= wr_command & w_strb_r[0] & w_data_r[`CMD_CLEAR];
      cmd_load_r <= wr_command & w_strb_r[0] & w_data_r[`CMD_LOAD];
      wraps_r <= wraps_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ============================================================
  // bus outputs
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;

endmodule // presettable_decade_counter

// ### sim/presettable_decade_counter_chk.sv
// port assertions for the decade counter
`timescale 1ns/100ps
module decade_chk
(
  input wire clock_i,
  input wire reset_i,
  input wire sync_clear_n_i,
  input wire load_n_i,
  input wire parallel_count_enable_i,
  input wire trickle_count_enable_i,
  input wire [3:0] preset_i,
  input wire [3:0] count_o,
  input wire ripple_carry_out_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o
);
  // ============================================================
  // helpers
  // pin view only: register commands and enable_src would break these
  wire both = parallel_count_enable_i & trickle_count_enable_i;
  wire run = sync_clear_n_i & load_n_i & both;
  wire idle = sync_clear_n_i & load_n_i & !both;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ============================================================
  // properties
  a_clear_zero: assert property (!sync_clear_n_i |=> count_o == 4'h0)
    else $error("clear missed");
  a_load_copy: assert property (sync_clear_n_i && !load_n_i |=> count_o == $past(preset_i))
    else $error("load missed");
  a_count_step: assert property (run && count_o < 4'h9 |=> count_o == $past(count_o) + 4'h1)
    else $error("step wrong");
  a_wrap_nine: assert property (run && count_o == 4'h9 |=> count_o == 4'h0)
    else $error("wrap wrong");
  a_hold_idle: assert property (idle |=> $stable(count_o))
    else $error("hold broken");
  a_carry_exact: assert property (ripple_carry_out_o == (trickle_count_enable_i && count_o == 4'h9))
    else $error("carry wrong");
  a_invalid_exit: assert property (run && count_o > 4'h9 ##1 run |=> count_o <= 4'h9)
    else $error("no recovery");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read late");
endmodule // decade_chk

bind presettable_decade_counter decade_chk u_chk (.clock_i, .reset_i, .sync_clear_n_i,
  .load_n_i, .parallel_count_enable_i, .trickle_count_enable_i, .preset_i, .count_o,
  .ripple_carry_out_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o);

// ### sim/tens_digit.sv
// behavioural next cascaded stage fed by the units carry
`timescale 1ns/100ps
module tens_digit
(
  input wire clock_i,
  input wire reset_i,
  input wire clear_n_i,
  input wire carry_i,
  output logic [3:0] tens_o
);
  // carry feeds both enables of this stage
  always @(posedge clock_i)
  begin
    if (reset_i || !clear_n_i)
      tens_o <= 4'h0;
    else if (carry_i)
      tens_o <= (tens_o == 4'h9) ? 4'h0 : tens_o + 4'h1;
  end
endmodule // tens_digit

// ### sim/tb_presettable_decade_counter.sv
// self-checking bench for the decade counter
`timescale 1ns/100ps
`include "counter_defs.vh"
module tb_presettable_decade_counter;
  logic clock_i, reset_i, cl_n, ld_n, pe, te;
  logic [3:0] pd, m, m10;
  logic [7:0] aw, ar;
  logic [31:0] wd, d, r;
  logic awv, wv, br, arv, rr;
  wire [3:0] cnt, tens;
  wire ripple_carry_out, awr, wr, bv, arr, rv;
  wire [1:0] bre, rre;
  wire [31:0] rd;
  logic [1:0] rs;
  int miscompares = 0;
  int comparisons = 0;
  int mw = 0;
  logic [1:0] mf = 2'h0;
  int i;
  presettable_decade_counter u_dut (.clock_i(clock_i), .reset_i(reset_i),
    .sync_clear_n_i(cl_n), .load_n_i(ld_n), .parallel_count_enable_i(pe),
    .trickle_count_enable_i(te), .preset_i(pd), .count_o(cnt), .ripple_carry_out_o(ripple_carry_out),
    .s_axi_awaddr_i(aw), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ar),
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr));
  tens_digit u_tens (.clock_i(clock_i), .reset_i(reset_i), .clear_n_i(cl_n), .carry_i(ripple_carry_out),
    .tens_o(tens));
  // ============================================================
  // helpers
  task end_sim;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      comparisons++;
      if (s !== e)
      begin
        miscompares++;
        $display("ERROR %s exp %h saw %h", n, e, s);
      end
    end
  endtask
  // pins change at the edge; the model steps with what the next edge takes
  task step(input logic c, input logic l, input logic p, input logic t, input logic [3:0] v);
    begin
      @(posedge clock_i);
      cl_n <= c;
      ld_n <= l;
      pe <= p;
      te <= t;
      pd <= v;
      @(negedge clock_i);
      chk("count", cnt, m);
      chk("carry", ripple_carry_out, t && m == 4'h9);
      chk("tens", tens, m10);
      if (m > 4'h9)
        mf[0] = 1'b1;
      if (c && l && p && t && m == 4'h9)
      begin
        mw++;
        mf[1] = 1'b1;
      end
      if (!c)
        m10 = 4'h0;
      else if (t && m == 4'h9)
        m10 = (m10 == 4'h9) ? 4'h0 : m10 + 4'h1;
      if (!c)
        m = 4'h0;
      else if (!l)
        m = v;
      else if (p && t)
        m = (m == 4'h9) ? 4'h0 : (m > 4'h9 && m[0]) ? 4'h1 - m : m + 4'h1;
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge clock_i);
      aw <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do
      begin
        @(posedge clock_i);
        if (awr)
          awv <= 1'b0;
        if (wr)
          wv <= 1'b0;
      end while (!bv);
      rs = bre;
      br <= 1'b0;
    end
  endtask
  task axr(input logic [7:0] a);
    begin
      @(posedge clock_i);
      ar <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do
      begin
        @(posedge clock_i);
        if (arr)
          arv <= 1'b0;
      end while (!rv);
      d = rd;
      rs = rre;
      rr <= 1'b0;
    end
  endtask
  // ============================================================
  // clock, watchdog and tests
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial
  begin
    #200000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    // all five pins in one packed assignment: reset, clear and load high, both enables low
    {reset_i, cl_n, ld_n, pe, te} = 5'b11100;
    pd = 4'h0;
    m = 4'h0;
    m10 = 4'h0;
    {aw, ar, wd, awv, wv, br, arv, rr} = '0;
    void'($urandom(32'hba62));
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    step(1'b0, 1'b0, 1'b1, 1'b1, 4'h5); // clear beats load and enables
    step(1'b1, 1'b0, 1'b1, 1'b1, 4'h7);
    repeat (7) step(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
    step(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
    step(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
    $display("walk test done");
    for (i = 0; i < 16; i++)
    begin
      step(1'b1, 1'b0, 1'b0, 1'b0, i[3:0]);
      repeat (2) step(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
    end
    $display("preset test done");
    repeat (300)
    begin
      r = $urandom;
      step(r[2:0] != 3'h0, r[5:3] != 3'h0, r[6], r[7] | r[12], r[11:8]);
    end
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h3);
    repeat (2) step(1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
    $display("random test done");
    axw(`REG_PRESET, 32'h5);
    chk("preset wr resp", rs, `RESP_OKAY);
    axr(`REG_PRESET);
    chk("preset", d, 32'h5);
    axr(`REG_STATUS);
    chk("status count", d[3:0], m);
    axr(8'h3c);
    chk("unmapped rd resp", rs, `RESP_SLVERR);
    axw(8'h3c, 32'h1);
    chk("unmapped wr resp", rs, `RESP_SLVERR);
    axr(`REG_WRAPS);
    chk("wraps", d, mw);
    axr(`REG_FLAGS);
    chk("flags", d, {30'h0, mf});
    axw(`REG_FLAGS, 32'h3);
    axw(`REG_WRAPS, 32'h0);
    axr(`REG_FLAGS);
    chk("flags clr", d, 32'h0);
    axr(`REG_WRAPS);
    chk("wraps clr", d, 32'h0);
    $display("register test done");
    end_sim;
  end
endmodule // tb_presettable_decade_counter
